// ### rtl/tac_defines.vh
// Constants of the tag command interpreter: command codes, frame lengths,
// tag states, engine states and block address limits.
// Assumes it is included by bare name from the design files under rtl/.
`ifndef TAC_DEFINES_VH
`define TAC_DEFINES_VH

// Command codes (first request byte), anticollision subcodes (second byte) and probe code (bits 3..0).
`define TAC_CMD_ANTICOL      8'h06
`define TAC_SUB_START        8'h00
`define TAC_SUB_CALL16       8'h04
`define TAC_PROBE_CODE       4'h6
`define TAC_CMD_READ_BLOCK   8'h08
`define TAC_CMD_RETURN_INV   8'h0c
`define TAC_CMD_SELECT       8'h0e
`define TAC_CMD_REQUEST_A    8'h0f

// Payload lengths in bytes, trailing check bytes not counted.
`define TAC_LEN_ONE          2'h1
`define TAC_LEN_TWO          2'h2

// Tag states.
`define TAC_ST_READY         3'h0
`define TAC_ST_B             3'h1
`define TAC_ST_SELECTED      3'h2
`define TAC_ST_C             3'h3
`define TAC_ST_D             3'h4

// Engine states.
`define TAC_ENG_IDLE         2'h0
`define TAC_ENG_MEM          2'h1
`define TAC_ENG_SEND         2'h2

// Block addresses.
`define TAC_ADDR_LAST_USER   8'h0f
`define TAC_ADDR_SYSTEM      8'hff

// Answer lengths in bytes.
`define TAC_ANS_ID           3'h1
`define TAC_ANS_BLOCK        3'h4

// Value of the slot that answers a sixteen-slot call.
`define TAC_SLOT_ZERO        4'h0

`endif

// ### rtl/tac_cmd_fsm.v
// Command decoder and state machine of a contactless memory tag.
// Assumes a frame receiver that strips start, end and check bytes, delivers
// payload bytes one per strobe and reports the check result with the end
// strobe; a frame transmitter that appends the check bytes and serialises
// each byte least significant bit first; a memory read port and a random source.
// The only reset is loss of the reader field.
`include "tac_defines.vh"
`default_nettype none

// Overview of operation
// - In ready, start request enters state_b, draws random identifier, answers it.
// - Start request is answered without looking at the slot value.
// - Sixteen-slot call acts only in state_b; ignored elsewhere.
// - Sixteen-slot call replaces the four low identifier bits with random 0..15.
// - Slot value stays until next sixteen-slot call or field loss.
// - After sixteen-slot call answer identifier only when new slot is zero.
// - Slot probe byte holds 6 in bits 3..0 and slot 1..15 above.
// - In state_b, slot probe answers identifier when its slot matches ours.
// - Select request with matching identifier enters selected and echoes identifier.
// - Before selection only anticollision requests act; others are dropped.
// - In selected, a select with another identifier moves to state_c.
// - In selected, request_a enters state_d silently; decoding stops until field loss.
// - Request_a is ignored outside the selected state.
// - In selected, return-to-state_b request goes to state_b silently.
// - Return-to-state_b request is ignored outside the selected state.
// - Block read fetches the addressed block and answers its four bytes.
// - Block bytes go least significant first, each byte least significant bit first.
// - Block read accepts addresses 0..15 and 255; others get no answer.
// - Block read acts only in the selected state; earlier ones are ignored.
// - After power-on the tag is ready and answers only the start request.
module tac_cmd_fsm (
  // Clock and field reset
  input  wire        clock,
  input  wire        reset,
  // Request byte stream from the frame receiver
  input  wire        rxValid,
  input  wire [7:0]  rxData,
  input  wire        rxEnd,
  input  wire        rxCrcOk,
  // Answer byte stream to the frame transmitter
  output reg         txValid,
  output reg  [7:0]  txData,
  output reg         txLast,
  input  wire        txReady,
  // Memory block read port
  output reg         memReq,
  output reg  [7:0]  memAddr,
  input  wire        memAck,
  input  wire [31:0] memData,
  // Random number source
  input  wire [7:0]  randomValue,
  // Status
  output reg  [2:0]  tagState,
  output reg  [7:0]  tagIdentifier
);

  // Payload capture.
  reg  [7:0]  byte0_reg;
  reg  [7:0]  byte1_reg;
  reg  [1:0]  rxCount_reg;
  reg         rxOverflow_reg;

  // Engine and answer shifter.
  reg  [1:0]  engine_reg;
  reg  [31:0] txBuf_reg;
  reg  [2:0]  txLeft_reg;

  wire        lenOne;
  wire        lenTwo;
  wire        isStart;
  wire        isCall16;
  wire        isProbe;
  wire        isSelect;
  wire        isRequestA;
  wire        isReturnInv;
  wire        isReadBlock;
  wire [3:0]  newSlot;
  wire [3:0]  probeSlotValue;
  wire        idMatch;
  wire        decodeNow;

  // Addresses 0..15 and the system block are served; anything else is not.
  function blockAddrOk;
    input [7:0] addr;
    begin
      blockAddrOk = (addr <= `TAC_ADDR_LAST_USER) || (addr == `TAC_ADDR_SYSTEM);
    end
  endfunction

  // Frames of unexpected length fall through every decode term and are dropped.
  assign lenOne         = (rxCount_reg == `TAC_LEN_ONE) && !rxOverflow_reg;
  assign lenTwo         = (rxCount_reg == `TAC_LEN_TWO) && !rxOverflow_reg;
  assign isStart        = lenTwo && (byte0_reg == `TAC_CMD_ANTICOL) && (byte1_reg == `TAC_SUB_START);
  assign isCall16       = lenTwo && (byte0_reg == `TAC_CMD_ANTICOL) && (byte1_reg == `TAC_SUB_CALL16);
  assign probeSlotValue = byte0_reg[7:4];
  assign isProbe        = lenOne && (byte0_reg[3:0] == `TAC_PROBE_CODE)
                          && (probeSlotValue != `TAC_SLOT_ZERO);
  assign isSelect       = lenTwo && (byte0_reg == `TAC_CMD_SELECT);
  assign isRequestA     = lenOne && (byte0_reg == `TAC_CMD_REQUEST_A);
  assign isReturnInv    = lenOne && (byte0_reg == `TAC_CMD_RETURN_INV);
  assign isReadBlock    = lenTwo && (byte0_reg == `TAC_CMD_READ_BLOCK);
  assign newSlot        = randomValue[3:0];
  assign idMatch        = (byte1_reg == tagIdentifier);
  // A frame with a bad check word, or any frame once in state_d, is never decoded.
  assign decodeNow      = rxEnd && rxCrcOk && (tagState != `TAC_ST_D);

  // Payload capture: the first two bytes are kept, longer frames are flagged.
  // The byte count is cleared by the end strobe in the same edge at which the
  // decoder reads it; the decoder sees the old count through non-blocking
  // assignment, so a back-to-back frame can start on the very next cycle.
  // Bytes are not stored while an answer or a block fetch is pending. A frame
  // that overlaps an answer is therefore cut short, and only bytes stored after the answer reach decode;
  // the reader is expected to wait for the answer before it sends again.
  always @(posedge clock) begin
    if (reset) begin
      byte0_reg      <= 8'h00;
      byte1_reg      <= 8'h00;
      rxCount_reg    <= 2'h0;
      rxOverflow_reg <= 1'b0;
    end else if (rxEnd) begin
      rxCount_reg    <= 2'h0;
      rxOverflow_reg <= 1'b0;
    end else if (rxValid && (engine_reg == `TAC_ENG_IDLE)) begin
      if (rxCount_reg == 2'h0) begin
        byte0_reg <= rxData;
      end
      if (rxCount_reg == 2'h1) begin
        byte1_reg <= rxData;
      end
      if (rxCount_reg == `TAC_LEN_TWO) begin
        rxOverflow_reg <= 1'b1;
      end else begin
        rxCount_reg <= rxCount_reg + 2'h1;
      end
    end
  end

  // Tag state machine, decode and answer engine.
  // Identifier answers are loaded straight into the output byte, so the
  // answer appears one cycle after the end strobe. Block answers wait for
  // the memory acknowledge, then leave one byte per accepted transfer.
  // The random source is sampled only at the decoding edge; between draws
  // the slot value lives in the low nibble of the identifier and nowhere else,
  // which keeps the probe compare and the echoed identifier consistent.
  // Once state_d, the decode enable is held off until field loss, so
  // no later request, however well formed, can move the state again.
  always @(posedge clock) begin
    if (reset) begin
      tagState      <= `TAC_ST_READY;
      tagIdentifier <= 8'h00;
      engine_reg    <= `TAC_ENG_IDLE;
      txBuf_reg     <= 32'h00000000;
      txLeft_reg    <= 3'h0;
      txValid       <= 1'b0;
      txData        <= 8'h00;
      txLast        <= 1'b0;
      memReq        <= 1'b0;
      memAddr       <= 8'h00;
    end else begin
      memReq <= 1'b0;
      case (engine_reg)
        `TAC_ENG_IDLE: begin
          // Requests arriving while an answer is in flight are not decoded.
          if (decodeNow) begin
            case (tagState)
              `TAC_ST_READY: begin
                // Only the start request is heard here.
                if (isStart) begin
                  tagState      <= `TAC_ST_B;
                  tagIdentifier <= randomValue;
                  txBuf_reg     <= {24'h000000, randomValue};
                  txData        <= randomValue;
                  txLeft_reg    <= `TAC_ANS_ID;
                  txLast        <= 1'b1;
                  txValid       <= 1'b1;
                  engine_reg    <= `TAC_ENG_SEND;
                end
              end
              `TAC_ST_B: begin
                if (isCall16) begin
                  // The slot is held in the identifier until the next draw.
                  tagIdentifier <= {tagIdentifier[7:4], newSlot};
                  if (newSlot == `TAC_SLOT_ZERO) begin
                    txBuf_reg  <= {24'h000000, tagIdentifier[7:4], newSlot};
                    txData     <= {tagIdentifier[7:4], newSlot};
                    txLeft_reg <= `TAC_ANS_ID;
                    txLast     <= 1'b1;
                    txValid    <= 1'b1;
                    engine_reg <= `TAC_ENG_SEND;
                  end
                end else if (isProbe) begin
                  if (probeSlotValue == tagIdentifier[3:0]) begin
                    txBuf_reg  <= {24'h000000, tagIdentifier};
                    txData     <= tagIdentifier;
                    txLeft_reg <= `TAC_ANS_ID;
                    txLast     <= 1'b1;
                    txValid    <= 1'b1;
                    engine_reg <= `TAC_ENG_SEND;
                  end
                end else if (isSelect && idMatch) begin
                  tagState   <= `TAC_ST_SELECTED;
                  txBuf_reg  <= {24'h000000, tagIdentifier};
                  txData     <= tagIdentifier;
                  txLeft_reg <= `TAC_ANS_ID;
                  txLast     <= 1'b1;
                  txValid    <= 1'b1;
                  engine_reg <= `TAC_ENG_SEND;
                end
                // Every other request is dropped before selection.
              end
              `TAC_ST_C: begin
                // A state_c tag can be picked again by its own identifier.
                if (isSelect && idMatch) begin
                  tagState   <= `TAC_ST_SELECTED;
                  txBuf_reg  <= {24'h000000, tagIdentifier};
                  txData     <= tagIdentifier;
                  txLeft_reg <= `TAC_ANS_ID;
                  txLast     <= 1'b1;
                  txValid    <= 1'b1;
                  engine_reg <= `TAC_ENG_SEND;
                end
              end
              `TAC_ST_SELECTED: begin
                if (isSelect) begin
                  if (idMatch) begin
                    txBuf_reg  <= {24'h000000, tagIdentifier};
                    txData     <= tagIdentifier;
                    txLeft_reg <= `TAC_ANS_ID;
                    txLast     <= 1'b1;
                    txValid    <= 1'b1;
                    engine_reg <= `TAC_ENG_SEND;
                  end else begin
                    tagState <= `TAC_ST_C;
                  end
                end else if (isRequestA) begin
                  tagState <= `TAC_ST_D;
                end else if (isReturnInv) begin
                  tagState <= `TAC_ST_B;
                end else if (isReadBlock && blockAddrOk(byte1_reg)) begin
                  memAddr    <= byte1_reg;
                  memReq     <= 1'b1;
                  engine_reg <= `TAC_ENG_MEM;
                end
              end
              default: begin
                tagState <= tagState;
              end
            endcase
          end
        end
        `TAC_ENG_MEM: begin
          if (memAck) begin
            txBuf_reg  <= memData;
            txData     <= memData[7:0];
            txLeft_reg <= `TAC_ANS_BLOCK;
            txLast     <= 1'b0;
            txValid    <= 1'b1;
            engine_reg <= `TAC_ENG_SEND;
          end
        end
        `TAC_ENG_SEND: begin
          if (txReady) begin
            if (txLeft_reg == 3'h1) begin
              txValid    <= 1'b0;
              txLast     <= 1'b0;
              engine_reg <= `TAC_ENG_IDLE;
            end else begin
              // Bytes leave low byte first; the transmitter shifts bits LSB first.
              txBuf_reg  <= {8'h00, txBuf_reg[31:8]};
              txData     <= txBuf_reg[15:8];
              txLast     <= (txLeft_reg == 3'h2);
              txLeft_reg <= txLeft_reg - 3'h1;
            end
          end
        end
        default: begin
          engine_reg <= `TAC_ENG_IDLE;
        end
      endcase
    end
  end

endmodule // tac_cmd_fsm

`default_nettype wire

// ### verif/tac_cmd_monitor.sv
// Checker of the tag command interpreter, watching only its ports.
// Assumes one clock and a synchronous active-high reset; bound from the bench.
`include "tac_defines.vh"
`default_nettype none
module tac_cmd_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // Request and answer streams
  input wire logic        rxValid,
  input wire logic [7:0]  rxData,
  input wire logic        rxEnd,
  input wire logic        rxCrcOk,
  input wire logic        txValid,
  input wire logic [7:0]  txData,
  input wire logic        txLast,
  input wire logic        txReady,
  // Memory port, random source and status
  input wire logic        memReq,
  input wire logic [7:0]  memAddr,
  input wire logic        memAck,
  input wire logic [31:0] memData,
  input wire logic [7:0]  randomValue,
  input wire logic [2:0]  tagState,
  input wire logic [7:0]  tagIdentifier
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // The first block byte must be the low byte of the fetched word.
  sequence s_fetch;
    memAck ##1 (txValid && txData == $past(memData[7:0]));
  endsequence
  sequence s_decoded;
    $past(rxEnd) && tagState == `TAC_ST_SELECTED;
  endsequence
  a_tx_holds: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
    else $error("answer byte changed before it was taken");
  a_block_low_first: assert property (memAck |-> s_fetch)
    else $error("block answer does not start with the low byte");
  a_read_selected: assert property (memReq |-> s_decoded)
    else $error("block fetch outside the selected state");
  a_read_range: assert property (memReq |-> memAddr <= `TAC_ADDR_LAST_USER || memAddr == `TAC_ADDR_SYSTEM)
    else $error("block fetch at an unserved address");
  a_fetch_pulse: assert property (memReq |=> !memReq && $stable(memAddr))
    else $error("fetch request not a single pulse");
  a_stays_deact: assert property (tagState == `TAC_ST_D |=> tagState == `TAC_ST_D && !txValid && !memReq)
    else $error("state_d tag acted");
  a_crc_drop: assert property (rxEnd && !rxCrcOk && !txValid |=> !txValid && !memReq && $stable(tagState))
    else $error("frame with bad check word was acted on");
  a_id_stable: assert property (!$stable(tagIdentifier) |-> $past(rxEnd))
    else $error("identifier changed without a request");
  a_state_cause: assert property (!$stable(tagState) |-> $past(rxEnd))
    else $error("state changed without a request");
  a_id_answer: assert property ($rose(txValid) && !$past(memAck) |-> txLast && txData == tagIdentifier)
    else $error("identifier answer differs from the identifier");
endmodule // tac_cmd_monitor
`default_nettype wire

// ### verif/tac_reader_model.sv
// Reader-side model: answers block fetches and sinks answer bytes.
// Assumes fetch pulses of the interpreter; stall makes the sink slow.
`default_nettype none
module tac_reader_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Memory port
  input  wire logic        memReq,
  input  wire logic [7:0]  memAddr,
  output var  logic        memAck,
  output var  logic [31:0] memData,
  // Answer sink
  input  wire logic        stall,
  output var  logic        txReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tick_reg;
  logic [1:0] wait_reg;
  always @(posedge clock) begin
    tick_reg <= reset ? 8'h00 : tick_reg + 8'h01;
    wait_reg <= reset ? 2'h0 : {wait_reg[0], memReq};
  end
  // Outside the acknowledge the data bus wanders, so a stale read never matches.
  always_comb begin
    memAck = wait_reg[1];
    memData = memAck ? {memAddr, memAddr ^ 8'h3c, ~memAddr, memAddr + 8'h11} : {4{tick_reg}};
    txReady = !stall || tick_reg[0];
  end
endmodule // tac_reader_model
`default_nettype wire

// ### verif/tb_top.sv
// Bench of the tag command interpreter: sends request frames, judges answers.
// Assumes the reader-side model for the memory port and the answer sink.
`include "tac_defines.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        rxValid = 1'b0;
  logic [7:0]  rxData = 8'h00;
  logic        rxEnd = 1'b0;
  logic        rxCrcOk = 1'b0;
  logic [7:0]  randomValue = 8'h00;
  logic        stall = 1'b0;
  wire         txValid, txLast, txReady, memReq, memAck;
  wire  [7:0]  txData, memAddr, tagIdentifier;
  wire  [31:0] memData;
  wire  [2:0]  tagState;
  int          num_errors = 0;
  int          total_checks = 0;
  always #2.5 clock = ~clock;
  tac_cmd_fsm tac_cmd_fsm_inst (.clock(clock), .reset(reset), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
    .rxCrcOk(rxCrcOk), .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady), .memReq(memReq),
    .memAddr(memAddr), .memAck(memAck), .memData(memData), .randomValue(randomValue), .tagState(tagState),
    .tagIdentifier(tagIdentifier));
  tac_reader_model tac_reader_model_inst (.clock(clock), .reset(reset), .memReq(memReq), .memAddr(memAddr),
    .memAck(memAck), .memData(memData), .stall(stall), .txReady(txReady));
  function automatic logic [31:0] word(input logic [7:0] a);
    return {a, a ^ 8'h3c, ~a, a + 8'h11};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input int n, input logic [7:0] b0, input logic [7:0] b1, input logic ok);
    @(negedge clock);
    rxValid = 1'b1;
    rxData = b0;
    if (n == 2) begin
      @(negedge clock);
      rxData = b1;
    end
    @(negedge clock);
    rxValid = 1'b0;
    rxData = ~rxData;
    rxEnd = 1'b1;
    rxCrcOk = ok;
    @(negedge clock);
    rxEnd = 1'b0;
  endtask
  // A byte seen valid and ready at a falling edge is taken at the next rising edge.
  task automatic answer(input int n, input logic [31:0] w);
    int k;
    for (int i = 0; i < n; i++) begin
      for (k = 0; k < 40 && !(txValid === 1'b1 && txReady === 1'b1); k++) @(negedge clock);
      // A missing answer would leave the last byte on txData, so validity is judged too.
      chk("txValid", 1'b1, txValid);
      chk("txData", w[8*i +: 8], txData);
      chk("txLast", i == n - 1, txLast);
      @(negedge clock);
    end
    chk("txValid after answer", 1'b0, txValid);
  endtask
  task automatic silent();
    repeat (8) begin
      @(negedge clock);
      chk("txValid silent", 1'b0, txValid);
    end
  endtask
  task automatic t_ready();
    send(2, 8'h06, 8'h04, 1'b1); silent();
    send(2, 8'h0e, 8'h00, 1'b1); silent();
    send(2, 8'h08, 8'h00, 1'b1); silent();
    chk("tagState", `TAC_ST_READY, tagState);
  endtask
  task automatic t_start();
    randomValue = 8'h35;
    send(2, 8'h06, 8'h00, 1'b1); answer(1, 8'h35);
    chk("tagState", `TAC_ST_B, tagState);
  endtask
  task automatic t_call16();
    randomValue = 8'h7a;
    send(2, 8'h06, 8'h04, 1'b1); silent();
    chk("tagIdentifier", 8'h3a, tagIdentifier);
    send(1, 8'h56, 8'h00, 1'b1); silent();
    send(1, 8'ha6, 8'h00, 1'b1); answer(1, 8'h3a);
    randomValue = 8'h91;
    send(2, 8'h06, 8'h04, 1'b0); silent();
    chk("tagIdentifier", 8'h3a, tagIdentifier);
    send(1, 8'h0f, 8'h00, 1'b1); silent();
    send(1, 8'h0c, 8'h00, 1'b1); silent();
    send(2, 8'h08, 8'h01, 1'b1); silent();
    chk("tagState", `TAC_ST_B, tagState);
    randomValue = 8'h90;
    send(2, 8'h06, 8'h04, 1'b1); answer(1, 8'h30);
  endtask
  task automatic t_select();
    send(2, 8'h0e, 8'h30, 1'b1); answer(1, 8'h30);
    chk("tagState", `TAC_ST_SELECTED, tagState);
    stall = 1'b1;
    send(2, 8'h08, 8'h0f, 1'b1); answer(4, word(8'h0f));
    send(2, 8'h08, 8'hff, 1'b1); answer(4, word(8'hff));
    send(2, 8'h08, 8'h10, 1'b1); silent();
    stall = 1'b0;
  endtask
  task automatic t_leave();
    send(2, 8'h0e, 8'h31, 1'b1); silent();
    chk("tagState", `TAC_ST_C, tagState);
    send(2, 8'h0e, 8'h30, 1'b1); answer(1, 8'h30);
    send(1, 8'h0c, 8'h00, 1'b1); silent();
    chk("tagState", `TAC_ST_B, tagState);
    send(2, 8'h0e, 8'h30, 1'b1); answer(1, 8'h30);
    send(1, 8'h0f, 8'h00, 1'b1); silent();
    send(2, 8'h06, 8'h00, 1'b1); silent();
    chk("tagState", `TAC_ST_D, tagState);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    reset = 1'b0;
    t_ready();
    t_start();
    t_call16();
    t_select();
    t_leave();
    give_verdict();
  end
  // The sequence needs about a thousand nanoseconds; this leaves ample margin.
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
endmodule // tb_top
bind tac_cmd_fsm tac_cmd_monitor tac_cmd_monitor_inst (.clock(clock), .reset(reset), .rxValid(rxValid),
  .rxData(rxData), .rxEnd(rxEnd), .rxCrcOk(rxCrcOk), .txValid(txValid), .txData(txData), .txLast(txLast),
  .txReady(txReady), .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memData(memData),
  .randomValue(randomValue), .tagState(tagState), .tagIdentifier(tagIdentifier));
`default_nettype wire
